// ==== design/fbs_status_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - Error code: 00 none, 02 program, 12 erase
// - Error register read-only, 16 bits, upper zero
// - Direction bit: 0 incremental, 1 decremental scan
// - Sequencer initialise resets the control register
// - Control register 8 bits, reset zero, reserved zero
// - Result bit: 0 erased, 1 programmed found
// - Capture 21-bit offset of first programmed location
// - Erased result leaves previous offset in place
// - Offset register 32-bit read-only, bits 31:21 zero
module fbs_status_regs
    import fbs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input fbs_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic seq_init,
    input wire logic pe_done,
    input wire logic erase_error_flag,
    input wire logic program_error_flag,
    input wire logic bc_start,
    input fbs_bc_hit_t bc_hit,
    input wire logic bc_done,
    output logic scan_direction_bit,
    output logic blank_result_bit,
    output logic [7:0] error_cause_code
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] error_cause_code_reg; // Last failure cause
    logic scan_direction_reg; // Software scan order
    logic run_direction_reg; // Order frozen for the running scan
    logic blank_result_reg; // Last blank-check outcome
    logic [20:0] programmed_offset_reg; // Offset of first programmed data
    fbs_bc_state_t bc_state_reg; // Scan progress
    logic [31:0] reg_rdata_next; // Read mux output
    logic cap_found; // Tracker saw a programmed location
    logic [20:0] cap_addr; // Tracker's best address
    logic cap_clear; // Restart the tracker

    // ****************************************
    // Program / erase failure cause
    // ****************************************
    // Updated only on completion with a raised flag; erase wins when both
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            error_cause_code_reg <= FBS_ERR_CODE_RST;
        end else if (pe_done && erase_error_flag) begin
            error_cause_code_reg <= FBS_ERR_ERASE;
        end else if (pe_done && program_error_flag) begin
            error_cause_code_reg <= FBS_ERR_PROGRAM;
        end
        // Otherwise held so the older cause stays visible
    end

    AST_ERASE_CODE: assert property (@(posedge clock) disable iff (!rst_n)
        pe_done && erase_error_flag |=> error_cause_code_reg == 8'h12)
        else $error("erase failure did not give code 12");

    AST_PROGRAM_CODE: assert property (@(posedge clock) disable iff (!rst_n)
        pe_done && program_error_flag && !erase_error_flag
        |=> error_cause_code_reg == 8'h02)
        else $error("program failure did not give code 02");

    AST_CODE_HELD: assert property (@(posedge clock) disable iff (!rst_n)
        !erase_error_flag && !program_error_flag
        |=> error_cause_code_reg == $past(error_cause_code_reg))
        else $error("error code changed without an error flag");

    // Reserved codes can never be stored, whatever the flags do
    AST_CODE_LEGAL: assert property (@(posedge clock) disable iff (!rst_n)
        error_cause_code_reg == 8'h00 || error_cause_code_reg == 8'h02
        || error_cause_code_reg == 8'h12)
        else $error("reserved error code stored");

    // ****************************************
    // Blank-check direction control
    // ****************************************
    // Only bit 0 is stored; reserved write data is dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scan_direction_reg <= FBS_CTRL_RST[FBS_SCAN_DIR_POS];
        end else if (seq_init) begin
            scan_direction_reg <= FBS_CTRL_RST[FBS_SCAN_DIR_POS];
        end else if (reg_req.wr && reg_req.addr == FBS_OFS_BC_CONTROL) begin
            scan_direction_reg <= reg_req.wdata[FBS_SCAN_DIR_POS];
        end
    end

    AST_INIT_CLEARS_DIR: assert property (@(posedge clock) disable iff (!rst_n)
        seq_init |=> !scan_direction_reg)
        else $error("sequencer initialise left direction set");

    AST_DIR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        reg_req.wr && reg_req.addr == FBS_OFS_BC_CONTROL && !seq_init
        |=> scan_direction_reg == $past(reg_req.wdata[0]))
        else $error("direction bit did not take written value");

    // Direction is driven to the engine through a second flop fed by the register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scan_direction_bit <= FBS_CTRL_RST[FBS_SCAN_DIR_POS];
        end else begin
            scan_direction_bit <= seq_init ? FBS_CTRL_RST[FBS_SCAN_DIR_POS]
                                           : scan_direction_reg;
        end
    end

    // Engine copy trails the register by one cycle; init forces zero
    AST_DIR_OUT: assert property (@(posedge clock) disable iff (!rst_n)
        !seq_init |=> scan_direction_bit == $past(scan_direction_reg))
        else $error("direction output lost the register value");

    // ****************************************
    // Blank-check sequence
    // ****************************************
    // Direction is frozen at start: a write mid-scan would mix two orders
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bc_state_reg <= FBS_BC_IDLE;
            run_direction_reg <= FBS_DIR_INCREMENTAL;
        end else begin
            unique case (bc_state_reg)
                FBS_BC_IDLE: begin
                    if (bc_start) begin
                        bc_state_reg <= FBS_BC_SCAN;
                        run_direction_reg <= scan_direction_reg;
                    end
                end
                FBS_BC_SCAN: begin
                    if (bc_done || seq_init) begin
                        bc_state_reg <= FBS_BC_IDLE;
                    end
                end
                default: begin
                    bc_state_reg <= FBS_BC_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Scan checks
    // ****************************************
    // Only the two one-hot codes may ever appear
    AST_STATE_ONEHOT: assert property (@(posedge clock) disable iff (!rst_n)
        $onehot(bc_state_reg))
        else $error("blank-check state left its one-hot codes");

    // Initialise abandons a running scan; results stay as they were unless done arrives in the same cycle
    AST_INIT_ABORTS: assert property (@(posedge clock) disable iff (!rst_n)
        seq_init && bc_state_reg == FBS_BC_SCAN |=> bc_state_reg == FBS_BC_IDLE)
        else $error("initialise did not stop the scan");

    // A repeated start mid-scan must not disturb the frozen order
    AST_ORDER_FROZEN: assert property (@(posedge clock) disable iff (!rst_n)
        bc_state_reg == FBS_BC_SCAN |=> run_direction_reg == $past(run_direction_reg))
        else $error("scan order changed during a scan");

    // Tracker restarts at every new scan
    assign cap_clear = bc_start && (bc_state_reg == FBS_BC_IDLE);

    fbs_offset_capture u_capture (
        .clock(clock),
        .rst_n(rst_n),
        .clear(cap_clear),
        .direction(run_direction_reg),
        .hit_valid(bc_hit.valid && bc_hit.programmed && bc_state_reg == FBS_BC_SCAN),
        .hit_addr(bc_hit.addr),
        .found(cap_found),
        .best_addr(cap_addr)
    );

    // Result and offset committed when done arrives during a scan
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blank_result_reg <= FBS_RESULT_RST;
            programmed_offset_reg <= FBS_OFFSET_RST;
        end else if (bc_done && bc_state_reg == FBS_BC_SCAN) begin
            blank_result_reg <= cap_found;
            if (cap_found) begin
                programmed_offset_reg <= cap_addr;
            end
            // Erased area: offset left as it was
        end
    end

    AST_RESULT_MATCHES: assert property (@(posedge clock) disable iff (!rst_n)
        bc_done && bc_state_reg == FBS_BC_SCAN
        |=> blank_result_reg == $past(cap_found))
        else $error("blank result disagrees with scan");

    AST_OFFSET_CAPTURED: assert property (@(posedge clock) disable iff (!rst_n)
        bc_done && bc_state_reg == FBS_BC_SCAN && cap_found
        |=> programmed_offset_reg == $past(cap_addr))
        else $error("programmed offset not captured");

    AST_OFFSET_HELD: assert property (@(posedge clock) disable iff (!rst_n)
        bc_done && bc_state_reg == FBS_BC_SCAN && !cap_found
        |=> $stable(programmed_offset_reg))
        else $error("erased result changed the offset");

    // A stray done outside a scan must leave the result alone
    AST_DONE_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
        bc_done && bc_state_reg == FBS_BC_IDLE |=> $stable(blank_result_reg))
        else $error("done outside a scan changed the result");

    // ****************************************
    // Read side
    // ****************************************
    // All registers read-only except control; narrow data in low bits
    always_comb begin
        reg_rdata_next = '0;
        unique case (reg_req.addr)
            FBS_OFS_ERROR_CAUSE: begin
                reg_rdata_next[FBS_ERR_CODE_W-1:0] = error_cause_code_reg;
            end
            FBS_OFS_BC_CONTROL: begin
                reg_rdata_next[FBS_SCAN_DIR_POS] = scan_direction_reg;
            end
            FBS_OFS_BC_RESULT: begin
                reg_rdata_next[FBS_RESULT_POS] = blank_result_reg;
            end
            FBS_OFS_FIRST_OFFSET: begin
                reg_rdata_next[FBS_OFFSET_W-1:0] = programmed_offset_reg;
            end
            default: begin
                reg_rdata_next = '0;
            end
        endcase
    end

    // Registered read data, one cycle after the request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_req.rd ? reg_rdata_next : '0;
            reg_rvalid <= reg_req.rd;
        end
    end

    AST_UPPER_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == FBS_OFS_ERROR_CAUSE
        |=> reg_rvalid && reg_rdata[31:8] == 24'h000000)
        else $error("error register upper bits not zero");

    AST_OFFSET_UPPER_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == FBS_OFS_FIRST_OFFSET
        |=> reg_rdata[31:21] == 11'h000 && reg_rdata[20:0] == $past(programmed_offset_reg))
        else $error("offset register read wrong");

    // ****************************************
    // Bus contract checks
    // ****************************************
    // Control and result registers carry one live bit each
    AST_CTRL_RESERVED: assert property (@(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == FBS_OFS_BC_CONTROL |=> reg_rdata[31:1] == 31'h0)
        else $error("control register reserved bits not zero");

    AST_RESULT_RESERVED: assert property (@(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == FBS_OFS_BC_RESULT |=> reg_rdata[31:1] == 31'h0)
        else $error("result register reserved bits not zero");

    // Read answer stands exactly one cycle; the bus idles at zero otherwise
    AST_RVALID_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> reg_rvalid == $past(reg_req.rd))
        else $error("read valid not one cycle after the request");

    AST_IDLE_DATA_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        !reg_req.rd |=> reg_rdata == 32'h0)
        else $error("read data not zero without a read");

    // ****************************************
    // Side outputs
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blank_result_bit <= FBS_RESULT_RST;
            error_cause_code <= FBS_ERR_CODE_RST;
        end else begin
            blank_result_bit <= blank_result_reg;
            error_cause_code <= error_cause_code_reg;
        end
    end

    // Side copies trail their registers by exactly one cycle
    AST_RESULT_OUT: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> blank_result_bit == $past(blank_result_reg))
        else $error("result output does not follow the register");

    AST_CAUSE_OUT: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> error_cause_code == $past(error_cause_code_reg))
        else $error("cause output does not follow the register");

endmodule

// ==== design/fbs_pkg.sv ====
package fbs_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] FBS_OFS_ERROR_CAUSE = 12'h0c0;
    localparam logic [11:0] FBS_OFS_BC_CONTROL = 12'h0d0;
    localparam logic [11:0] FBS_OFS_BC_RESULT = 12'h0d4;
    localparam logic [11:0] FBS_OFS_FIRST_OFFSET = 12'h0d8;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int FBS_ERR_CODE_W = 8;
    localparam int FBS_ERR_REG_W = 16;
    localparam int FBS_CTRL_REG_W = 8;
    localparam int FBS_OFFSET_W = 21;
    localparam int FBS_DATA_W = 32;
    localparam int FBS_SCAN_DIR_POS = 0;
    localparam int FBS_RESULT_POS = 0;
    localparam logic [7:0] FBS_ERR_CODE_RST = 8'h00;
    localparam logic [7:0] FBS_CTRL_RST = 8'h00;
    localparam logic [20:0] FBS_OFFSET_RST = 21'h0;
    localparam logic FBS_RESULT_RST = 1'b0;

    // ****************************************
    // Error cause codes
    // ****************************************
    localparam logic [7:0] FBS_ERR_NONE = 8'h00;
    localparam logic [7:0] FBS_ERR_PROGRAM = 8'h02;
    localparam logic [7:0] FBS_ERR_ERASE = 8'h12;

    // Scan order encodings
    localparam logic FBS_DIR_INCREMENTAL = 1'b0;
    localparam logic FBS_DIR_DECREMENTAL = 1'b1;

    // Register access request from the processor side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } fbs_reg_req_t;

    // One location checked by the blank-check engine
    typedef struct packed {
        logic valid;
        logic programmed;
        logic [20:0] addr;
    } fbs_bc_hit_t;

    // Blank-check progress
    typedef enum logic [1:0] {
        FBS_BC_IDLE = 2'b01,
        FBS_BC_SCAN = 2'b10
    } fbs_bc_state_t;

endpackage

// ==== design/fbs_offset_capture.sv ====
`timescale 1ns/1ps
module fbs_offset_capture
    import fbs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic direction,
    input wire logic hit_valid,
    input wire logic [20:0] hit_addr,
    output logic found,
    output logic [20:0] best_addr
);

    // ****************************************
    // Extreme-address tracker
    // ****************************************
    // Keeps lowest or highest programmed address, so the result does not
    // depend on the engine really walking in strict order.
    logic better;
    assign better = (direction == FBS_DIR_DECREMENTAL) ? (hit_addr > best_addr)
                                                       : (hit_addr < best_addr);

    // Found flag and best address
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            found <= 1'b0;
            best_addr <= FBS_OFFSET_RST;
        end else if (clear) begin
            found <= 1'b0;
        end else if (hit_valid && (!found || better)) begin
            found <= 1'b1;
            best_addr <= hit_addr;
        end
    end

    // Decremental keeps the maximum, incremental the minimum
    AST_EXTREME_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
        found && hit_valid && !clear && !better |=> best_addr == $past(best_addr))
        else $error("captured offset replaced by a worse address");

endmodule

// ==== verification/test_flash_result_and_blank_check_status.sv ====
`timescale 1ns/1ps
module test_flash_result_and_blank_check_status
    import fbs_pkg::*;
();
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clock;
    logic rst_n;
    fbs_reg_req_t reg_req; // Processor side access
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic seq_init;
    logic pe_done;
    logic erase_error_flag;
    logic program_error_flag;
    logic bc_start;
    fbs_bc_hit_t bc_hit; // One scanned location
    logic bc_done;
    logic scan_direction_bit;
    logic blank_result_bit;
    logic [7:0] error_cause_code;
    int miscompares;
    int checks;
    int cycles; // Hang guard

    fbs_status_regs uut (
        .clock(clock),
        .rst_n(rst_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .seq_init(seq_init),
        .pe_done(pe_done),
        .erase_error_flag(erase_error_flag),
        .program_error_flag(program_error_flag),
        .bc_start(bc_start),
        .bc_hit(bc_hit),
        .bc_done(bc_done),
        .scan_direction_bit(scan_direction_bit),
        .blank_result_bit(blank_result_bit),
        .error_cause_code(error_cause_code)
    );

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Whole run needs under a hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            test_done();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic test_done();
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Four-state compare, so unknowns never match
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Answer is registered on the taking edge and checked half a cycle later
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge clock);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(negedge clock);
        reg_req.rd = 1'b0;
        chk({31'h0, reg_rvalid}, 32'h1, "read valid");
        chk(reg_rdata, exp, "read data");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(negedge clock);
        reg_req.wr = 1'b0;
    endtask

    // Completion with flags sampled on the same edge
    task automatic pe(input logic e, input logic p);
        @(negedge clock);
        pe_done = 1'b1;
        erase_error_flag = e;
        program_error_flag = p;
        @(negedge clock);
        pe_done = 1'b0;
        erase_error_flag = 1'b0;
        program_error_flag = 1'b0;
    endtask

    // Start, two locations, then done
    task automatic bc(input logic [20:0] a0, input logic [20:0] a1, input logic p);
        @(negedge clock);
        bc_start = 1'b1;
        @(negedge clock);
        bc_start = 1'b0;
        bc_hit = '{1'b1, p, a0};
        @(negedge clock);
        bc_hit.addr = a1;
        @(negedge clock);
        bc_hit.valid = 1'b0;
        bc_done = 1'b1;
        @(negedge clock);
        bc_done = 1'b0;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        seq_init = 1'b0;
        pe_done = 1'b0;
        erase_error_flag = 1'b0;
        program_error_flag = 1'b0;
        bc_start = 1'b0;
        bc_hit = '0;
        bc_done = 1'b0;
        miscompares = 0;
        checks = 0;
        cycles = 0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        // Reset values and an unmapped place
        rd(FBS_OFS_ERROR_CAUSE, 32'h0);
        rd(FBS_OFS_BC_CONTROL, 32'h0);
        rd(FBS_OFS_BC_RESULT, 32'h0);
        rd(12'h0fc, 32'h0);
        // Reserved control bits read back zero
        wr(FBS_OFS_BC_CONTROL, 32'h0000_00ff);
        rd(FBS_OFS_BC_CONTROL, 32'h1);
        chk({31'h0, scan_direction_bit}, 32'h1, "direction");
        // Cause after program failure, both flags, a clean completion and a write
        pe(1'b0, 1'b1);
        rd(FBS_OFS_ERROR_CAUSE, 32'h02);
        chk({24'h0, error_cause_code}, 32'h02, "cause out");
        pe(1'b1, 1'b1);
        rd(FBS_OFS_ERROR_CAUSE, 32'h12);
        pe(1'b0, 1'b0);
        rd(FBS_OFS_ERROR_CAUSE, 32'h12);
        wr(FBS_OFS_ERROR_CAUSE, 32'h0);
        rd(FBS_OFS_ERROR_CAUSE, 32'h12);
        // Decremental scan keeps the highest address
        bc(21'h5, 21'h3, 1'b1);
        // Offset trusted only once the result reads 1
        rd(FBS_OFS_BC_RESULT, 32'h1);
        rd(FBS_OFS_FIRST_OFFSET, 32'h5);
        chk({31'h0, blank_result_bit}, 32'h1, "result out");
        // Incremental scan keeps the lowest address
        wr(FBS_OFS_BC_CONTROL, 32'h0);
        rd(FBS_OFS_BC_CONTROL, 32'h0);
        chk({31'h0, scan_direction_bit}, 32'h0, "direction");
        bc(21'h5, 21'h3, 1'b1);
        rd(FBS_OFS_FIRST_OFFSET, 32'h3);
        // Erased area leaves the old offset
        bc(21'h7, 21'h9, 1'b0);
        rd(FBS_OFS_BC_RESULT, 32'h0);
        rd(FBS_OFS_FIRST_OFFSET, 32'h3);
        // Top of the offset field, upper bits zero
        bc(21'h1fffff, 21'h1ffffe, 1'b1);
        rd(FBS_OFS_FIRST_OFFSET, 32'h001f_fffe);
        // Initialise mid-scan: scan dropped, colliding write lost
        wr(FBS_OFS_BC_CONTROL, 32'h1);
        @(negedge clock);
        bc_start = 1'b1;
        @(negedge clock);
        bc_start = 1'b0;
        bc_hit = '{1'b1, 1'b1, 21'h4};
        @(negedge clock);
        bc_hit.valid = 1'b0;
        seq_init = 1'b1;
        reg_req.wr = 1'b1;
        reg_req.addr = FBS_OFS_BC_CONTROL;
        reg_req.wdata = 32'h1;
        @(negedge clock);
        seq_init = 1'b0;
        reg_req.wr = 1'b0;
        bc_done = 1'b1;
        @(negedge clock);
        bc_done = 1'b0;
        rd(FBS_OFS_BC_CONTROL, 32'h0);
        chk({31'h0, scan_direction_bit}, 32'h0, "direction");
        rd(FBS_OFS_FIRST_OFFSET, 32'h001f_fffe);
        rd(FBS_OFS_BC_RESULT, 32'h1);
        // Reset in mid-run clears every register
        @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        rd(FBS_OFS_ERROR_CAUSE, 32'h0);
        rd(FBS_OFS_FIRST_OFFSET, 32'h0);
        rd(FBS_OFS_BC_RESULT, 32'h0);
        chk({24'h0, error_cause_code}, 32'h0, "cause out");
        test_done();
    end
endmodule
